/* design/tpp_top.sv */
// Paired lead/follower channel PWM generator with APB registers
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
// Notes on behaviour
// RL1: Kind 100b runs follower in one-count mode
// RL2: Trigger source 100b uses lead count-done
// RL3: Trigger-during-run bit accepts retrigger while counting
// RL4: Software sets edge select 00b here
// RL5: Split 0 on channels 1,3 keeps 16 bits
// RL6: Software clears chain bit; fixed on 5,7
// RL7: Count source 0 counts operation clock
// RL8: Code 00b picks clock zero, 10b one
// RL9: Writing output level drives pin directly
// RL10: Output enable lets counting move the pin
// RL11: Software clears lead output enable
// RL12: Software clears lead output level
// RL13: Polarity 0 active-high, 1 active-low
// RL14: Lead polarity kept 0; fixed on channel 0
// RL15: Mode bit 1: trigger sets, end resets
// RL16: Lead mode bit 0 is lead output mode
// RL17: Lead reloads at zero, raising count-done
// RL18: Active one tick after trigger, inactive at zero
// RL19: Zero gives 0%, large value gives 100%
// RL20: Both data registers load on lead count-done
module tpp_top #(
	parameter int MST_CH = 0,
	parameter int SLV_CH = 1,
	parameter int CNT_W = 16,
	parameter int DIV_W = 4
) (
	input  wire logic        core_clk,  // 50 MHz system clock
	input  wire logic        rst_b,     // Async reset, active low
	input  wire logic        psel,      // APB select
	input  wire logic        penable,   // APB access phase
	input  wire logic        pwrite,    // APB write
	input  wire logic [7:0]  paddr,     // APB byte address
	input  wire logic [31:0] pwdata,    // APB write data
	output logic      [31:0] prdata,    // APB read data
	output logic             pready,    // APB ready
	output logic             pslverr,   // APB error, unmapped address
	input  wire logic        follower_input_pin,       // Follower count pin
	output logic             pwm_output_pin,           // PWM output
	output logic             lead_output_pin,          // Lead channel output
	output logic             lead_count_done_irq,      // Lead count-done pulse
	output logic             follower_count_done_irq   // Follower end pulse
);
	localparam logic SLV_CHAIN_FIX = (SLV_CH == 5) || (SLV_CH == 7);
	localparam logic MST_CHAIN_FIX = (MST_CH == 0);
	localparam logic SPLIT_OK = (SLV_CH == 1) || (SLV_CH == 3);
	localparam logic [15:0] SLV_WMASK = SLV_CHAIN_FIX ?
		(tpp_pkg::MODE_WMASK & ~tpp_pkg::MODE_CHAIN_MASK) : tpp_pkg::MODE_WMASK;
	localparam logic [15:0] MST_WMASK = MST_CHAIN_FIX ?
		(tpp_pkg::MODE_WMASK & ~tpp_pkg::MODE_CHAIN_MASK) : tpp_pkg::MODE_WMASK;

	typedef struct packed {
		logic              ready;
		logic [31:0]       rdata;
		logic              err;
		logic [15:0]       slv_mode;
		logic [15:0]       lead_mode;
		logic [7:0]        lvl;
		logic [7:0]        oe;
		logic [7:0]        pol;
		logic [7:0]        om;
		logic [CNT_W-1:0]  ldata;
		logic [CNT_W-1:0]  fdata;
		logic              run;
		logic              sw_trig;
		logic [7:0]        presc;
		logic              pin_s1;
		logic              pin_s2;
		logic              pin_prev;
		logic              m_irq;
		logic              s_irq;
		logic              pend;
		logic              s_run;
		logic              pwm_pin;
		logic              lead_pin;
	} tpp_top_st_t;

	tpp_top_st_t q;
	tpp_top_st_t n;

	logic [1:0]       rst_sync_ff;
	logic             rst_n;
	logic             tick_zero;
	logic             tick_one;
	logic [CNT_W-1:0] m_cnt;
	logic [CNT_W-1:0] s_cnt;
	logic             m_load;
	logic             m_dec;
	logic             s_load;
	logic             s_dec;
	logic [CNT_W-1:0] f_eff;

	// Decode shared by read and write paths
	function automatic logic is_mapped(input logic [7:0] a);
		case (a)
			tpp_pkg::OFS_SLV_MODE, tpp_pkg::OFS_LEAD_MODE,
			tpp_pkg::OFS_OUT_LVL, tpp_pkg::OFS_OUT_EN,
			tpp_pkg::OFS_OUT_POL, tpp_pkg::OFS_OUT_MODE,
			tpp_pkg::OFS_LEAD_DATA, tpp_pkg::OFS_FOL_DATA,
			tpp_pkg::OFS_CTRL, tpp_pkg::OFS_PRESC,
			tpp_pkg::OFS_LEAD_CNT, tpp_pkg::OFS_FOL_STAT: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	// Prescaler pick; only bit 15 matters, so 01b aliases 00b and 11b aliases 10b
	function automatic logic pick_tick(input logic [1:0] cks, input logic t0,
		input logic t1);
		pick_tick = cks[1] ? t1 : t0;
	endfunction : pick_tick

	function automatic logic edge_hit(input logic [1:0] cis, input logic prev,
		input logic cur);
		case (cis)
			tpp_pkg::EDGE_FALL: edge_hit = prev & ~cur;
			tpp_pkg::EDGE_RISE: edge_hit = ~prev & cur;
			default: edge_hit = prev ^ cur;
		endcase
	endfunction : edge_hit

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	tpp_presc #(
		.DIV_W(DIV_W)
	) u_presc (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.div_zero  (q.presc[DIV_W-1:0]),
		.div_one   (q.presc[tpp_pkg::PRESC_ONE_LSB +: DIV_W]),
		.tick_zero (tick_zero),
		.tick_one  (tick_one)
	);

	tpp_cnt #(
		.W(CNT_W)
	) u_lead_cnt (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.load     (m_load),
		.load_val (q.ldata),
		.dec      (m_dec),
		.value    (m_cnt)
	);

	tpp_cnt #(
		.W(CNT_W)
	) u_fol_cnt (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.load     (s_load),
		.load_val (f_eff),
		.dec      (s_dec),
		.value    (s_cnt)
	);

	always_comb begin
		logic        wr;
		logic        rd;
		logic        m_tick;
		logic        s_tick;
		logic        start;
		logic        trig;
		logic        one_cnt;
		logic        s_set;
		logic        s_clr;
		logic [2:0]  sts;
		logic [31:0] rv;
		wr = 1'b0;
		rd = 1'b0;
		m_tick = 1'b0;
		s_tick = 1'b0;
		start = 1'b0;
		trig = 1'b0;
		one_cnt = 1'b0;
		s_set = 1'b0;
		s_clr = 1'b0;
		sts = 3'h0;
		rv = 32'h0000_0000;
		n = q;
		m_load = 1'b0;
		m_dec = 1'b0;
		s_load = 1'b0;
		s_dec = 1'b0;

		// APB: one wait state, answer registered
		wr = psel & penable & pwrite & q.ready;
		rd = psel & penable & ~q.ready;
		n.ready = psel & penable & ~q.ready;
		// Error flag stands only alongside its ready pulse
		n.err = rd & ~is_mapped(paddr);
		if (rd & ~pwrite) begin
			case (paddr)
				tpp_pkg::OFS_SLV_MODE: rv = {16'h0000, q.slv_mode};
				tpp_pkg::OFS_LEAD_MODE: rv = {16'h0000, q.lead_mode};
				tpp_pkg::OFS_OUT_LVL: rv = {24'h00_0000, q.lvl};
				tpp_pkg::OFS_OUT_EN: rv = {24'h00_0000, q.oe};
				tpp_pkg::OFS_OUT_POL: rv = {24'h00_0000, q.pol};
				tpp_pkg::OFS_OUT_MODE: rv = {24'h00_0000, q.om};
				tpp_pkg::OFS_LEAD_DATA: rv = 32'(q.ldata);
				tpp_pkg::OFS_FOL_DATA: rv = 32'(q.fdata);
				tpp_pkg::OFS_CTRL: rv = {31'h0000_0000, q.run};
				tpp_pkg::OFS_PRESC: rv = {24'h00_0000, q.presc};
				tpp_pkg::OFS_LEAD_CNT: rv = 32'(m_cnt);
				tpp_pkg::OFS_FOL_STAT: rv = {14'h0000, q.pend, q.s_run, 16'(s_cnt)};
				default: rv = 32'h0000_0000;
			endcase
			n.rdata = rv;
		end else if (rd) begin
			n.rdata = 32'h0000_0000;
		end

		n.sw_trig = 1'b0;
		if (wr) begin
			case (paddr)
				tpp_pkg::OFS_SLV_MODE: n.slv_mode = pwdata[15:0] & SLV_WMASK; // RL6
				tpp_pkg::OFS_LEAD_MODE: n.lead_mode = pwdata[15:0] & MST_WMASK;
				tpp_pkg::OFS_OUT_LVL: n.lvl = pwdata[7:0]; // RL9
				tpp_pkg::OFS_OUT_EN: n.oe = pwdata[7:0];
				tpp_pkg::OFS_OUT_POL: n.pol = pwdata[7:0] & tpp_pkg::OUT_FIX_WMASK; // RL14
				tpp_pkg::OFS_OUT_MODE: n.om = pwdata[7:0] & tpp_pkg::OUT_FIX_WMASK; // RL16
				tpp_pkg::OFS_LEAD_DATA: n.ldata = pwdata[CNT_W-1:0];
				tpp_pkg::OFS_FOL_DATA: n.fdata = pwdata[CNT_W-1:0];
				tpp_pkg::OFS_CTRL: begin
					n.run = pwdata[tpp_pkg::CTRL_RUN_BIT];
					start = pwdata[tpp_pkg::CTRL_RUN_BIT] & ~q.run;
					n.sw_trig = pwdata[tpp_pkg::CTRL_SWTRIG_BIT];
				end
				tpp_pkg::OFS_PRESC: n.presc = pwdata[7:0];
				default: n.presc = q.presc;
			endcase
		end

		// Count pin: two-stage synchroniser, then edge detect on stage two
		n.pin_s1 = follower_input_pin;
		n.pin_s2 = q.pin_s1;
		n.pin_prev = q.pin_s2;

		m_tick = pick_tick(q.lead_mode[tpp_pkg::MODE_PRESC_LSB +: 2], tick_zero,
			tick_one); // RL8
		if (q.slv_mode[tpp_pkg::MODE_CSRC_BIT]) begin
			s_tick = edge_hit(q.slv_mode[tpp_pkg::MODE_EDGE_LSB +: 2], q.pin_prev,
				q.pin_s2);
		end else begin
			s_tick = pick_tick(q.slv_mode[tpp_pkg::MODE_PRESC_LSB +: 2], tick_zero,
				tick_one); // RL7 RL8
		end

		// Lead channel: interval timer
		n.m_irq = 1'b0;
		if (start) begin
			m_load = 1'b1;
			n.m_irq = q.lead_mode[tpp_pkg::MODE_TRIGGER_DURING_RUN_BIT];
		end else if (q.run & m_tick) begin
			if (m_cnt == '0) begin
				m_load = 1'b1; // RL17 RL20
				n.m_irq = 1'b1;
			end else begin
				m_dec = 1'b1;
			end
		end

		// Follower trigger
		sts = q.slv_mode[tpp_pkg::MODE_TRIG_LSB +: 3];
		one_cnt = q.slv_mode[tpp_pkg::MODE_KIND_LSB +: 3] == tpp_pkg::KIND_ONE_COUNT; // RL1
		case (sts)
			tpp_pkg::TRIG_LEAD_IRQ: trig = q.m_irq; // RL2
			tpp_pkg::TRIG_SOFTWARE: trig = q.sw_trig;
			default: trig = 1'b0;
		endcase
		if (!one_cnt) begin
			n.pend = 1'b0;
			n.s_run = 1'b0;
		end else if (trig & (~q.s_run | q.slv_mode[tpp_pkg::MODE_TRIGGER_DURING_RUN_BIT])) begin
			n.pend = 1'b1; // RL3
		end

		// Split keeps only the low byte; cleared it is a full 16-bit count
		f_eff = (SPLIT_OK && q.slv_mode[tpp_pkg::MODE_CHAIN_BIT]) ?
			{{(CNT_W-8){1'b0}}, q.fdata[7:0]} : q.fdata; // RL5

		// Follower: load one tick after trigger, end on reaching zero
		n.s_irq = 1'b0;
		if (one_cnt & s_tick) begin
			if (q.pend) begin
				s_load = 1'b1; // RL20
				n.pend = trig & q.slv_mode[tpp_pkg::MODE_TRIGGER_DURING_RUN_BIT];
				n.s_run = f_eff != '0; // RL19
				s_set = f_eff != '0; // RL18
				s_clr = f_eff == '0; // RL19
			end else if (q.s_run) begin
				s_dec = 1'b1;
				if (s_cnt == {{(CNT_W-1){1'b0}}, 1'b1}) begin
					n.s_run = 1'b0;
					n.s_irq = 1'b1;
					s_clr = 1'b1; // RL18
				end
			end
		end

		// Counting moves the follower level only when enabled
		if (q.oe[SLV_CH]) begin
			if (q.om[SLV_CH]) begin
				if (s_set) begin
					n.lvl[SLV_CH] = ~q.pol[SLV_CH]; // RL15 RL13 RL10
				end else if (s_clr) begin
					n.lvl[SLV_CH] = q.pol[SLV_CH]; // RL15 RL13 RL10
				end
			end else if (n.s_irq) begin
				n.lvl[SLV_CH] = ~q.lvl[SLV_CH]; // RL10
			end
		end
		// Lead output mode toggles on count-done
		if (q.oe[MST_CH] & ~q.om[MST_CH] & n.m_irq) begin
			n.lvl[MST_CH] = ~q.lvl[MST_CH]; // RL16 RL10
		end

		n.pwm_pin = n.lvl[SLV_CH]; // RL9
		n.lead_pin = n.lvl[MST_CH];
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.slv_mode <= tpp_pkg::RST_MODE;
			q.lead_mode <= tpp_pkg::RST_MODE;
			q.lvl <= tpp_pkg::RST_OUT;
			q.oe <= tpp_pkg::RST_OUT;
			q.pol <= tpp_pkg::RST_OUT;
			q.om <= tpp_pkg::RST_OUT;
			q.ldata <= tpp_pkg::RST_DATA[CNT_W-1:0];
			q.fdata <= tpp_pkg::RST_DATA[CNT_W-1:0];
			q.presc <= tpp_pkg::RST_PRESC;
		end else begin
			q <= n;
		end
	end

	assign prdata = q.rdata;
	assign pready = q.ready;
	assign pslverr = q.err;
	assign pwm_output_pin = q.pwm_pin;
	assign lead_output_pin = q.lead_pin;
	assign lead_count_done_irq = q.m_irq;
	assign follower_count_done_irq = q.s_irq;
endmodule : tpp_top

/* design/tpp_pkg.sv */
// Shared constants for the paired-channel PWM block
package tpp_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_SLV_MODE = 8'h00;
	localparam logic [7:0] OFS_LEAD_MODE = 8'h04;
	localparam logic [7:0] OFS_OUT_LVL = 8'h08;
	localparam logic [7:0] OFS_OUT_EN = 8'h0C;
	localparam logic [7:0] OFS_OUT_POL = 8'h10;
	localparam logic [7:0] OFS_OUT_MODE = 8'h14;
	localparam logic [7:0] OFS_LEAD_DATA = 8'h18;
	localparam logic [7:0] OFS_FOL_DATA = 8'h1C;
	localparam logic [7:0] OFS_CTRL = 8'h20;
	localparam logic [7:0] OFS_PRESC = 8'h24;
	localparam logic [7:0] OFS_LEAD_CNT = 8'h28;
	localparam logic [7:0] OFS_FOL_STAT = 8'h2C;
	// Mode register fields
	localparam int MODE_TRIGGER_DURING_RUN_BIT = 0;
	localparam int MODE_KIND_LSB = 1;
	localparam int MODE_EDGE_LSB = 6;
	localparam int MODE_TRIG_LSB = 8;
	localparam int MODE_CHAIN_BIT = 11;
	localparam int MODE_CSRC_BIT = 12;
	localparam int MODE_PRESC_LSB = 14;
	localparam logic [2:0] KIND_ONE_COUNT = 3'h4;
	localparam logic [2:0] TRIG_SOFTWARE = 3'h0;
	localparam logic [2:0] TRIG_LEAD_IRQ = 3'h4;
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	// Bits 5:4 and 13 always read zero
	localparam logic [15:0] MODE_WMASK = 16'hDFCF;
	localparam logic [15:0] MODE_CHAIN_MASK = 16'h0800;
	// Channel 0 polarity and mode bits are fixed at zero
	localparam logic [7:0] OUT_FIX_WMASK = 8'hFE;
	// Control and prescaler register fields
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_SWTRIG_BIT = 1;
	localparam int PRESC_ONE_LSB = 4;
	// Reset values
	localparam logic [15:0] RST_MODE = 16'h0000;
	localparam logic [7:0] RST_OUT = 8'h00;
	localparam logic [15:0] RST_DATA = 16'h0000;
	localparam logic [7:0] RST_PRESC = 8'h00;
endpackage : tpp_pkg

/* design/tpp_presc.sv */
// Prescaler producing the two selectable count-clock ticks
`timescale 1ns/1ns
module tpp_presc #(
	parameter int DIV_W = 4
) (
	input  wire logic             core_clk, // System clock
	input  wire logic             rst_n,    // Synchronised reset, active low
	input  wire logic [DIV_W-1:0] div_zero, // Log2 divide for clock zero
	input  wire logic [DIV_W-1:0] div_one,  // Log2 divide for clock one
	output logic                  tick_zero, // Prescaler clock zero tick
	output logic                  tick_one   // Prescaler clock one tick
);
	localparam int CW = 1 << DIV_W;

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          t0;
		logic          t1;
	} tpp_presc_st_t;

	tpp_presc_st_t q;
	tpp_presc_st_t n;
	logic [CW-1:0] m0;
	logic [CW-1:0] m1;

	always_comb begin
		m0 = ~({CW{1'b1}} << div_zero);
		m1 = ~({CW{1'b1}} << div_one);
		n = q;
		n.cnt = q.cnt + 1'b1;
		n.t0 = (q.cnt & m0) == m0;
		n.t1 = (q.cnt & m1) == m1;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign tick_zero = q.t0;
	assign tick_one = q.t1;
endmodule : tpp_presc

/* design/tpp_cnt.sv */
// Loadable down counter shared by both channels
`timescale 1ns/1ns
module tpp_cnt #(
	parameter int W = 16
) (
	input  wire logic         core_clk, // System clock
	input  wire logic         rst_n,    // Synchronised reset, active low
	input  wire logic         load,     // Load request, wins over dec
	input  wire logic [W-1:0] load_val, // Value to load
	input  wire logic         dec,      // Count down one
	output logic [W-1:0]      value     // Current count
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} tpp_cnt_st_t;

	tpp_cnt_st_t q;
	tpp_cnt_st_t n;

	always_comb begin
		n = q;
		if (load) begin
			n.cnt = load_val;
		end else if (dec) begin
			n.cnt = q.cnt - 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign value = q.cnt;
endmodule : tpp_cnt

/* bench/tpp_top_chk.sv */
// Port checker for the paired-channel PWM block
`timescale 1ns/1ns
module tpp_top_chk #(
	parameter int MST_CH = 0,
	parameter int SLV_CH = 1
) (
	input wire logic        core_clk,               // Clock
	input wire logic        rst_b,                  // Reset, active low
	input wire logic        psel,                   // APB select
	input wire logic        penable,                // APB access
	input wire logic        pwrite,                 // APB write
	input wire logic [7:0]  paddr,                  // APB address
	input wire logic [31:0] pwdata,                 // APB write data
	input wire logic        pready,                 // APB ready
	input wire logic        pslverr,                // APB error
	input wire logic        pwm_output_pin,         // PWM pin
	input wire logic        lead_output_pin,        // Lead pin
	input wire logic        follower_count_done_irq // Follower end pulse
);
	logic       wr_ok;
	logic [7:0] en_ff;
	logic [7:0] pol_ff;
	logic [7:0] om_ff;
	logic [1:0] qt_ff;

	assign wr_ok = psel && penable && pready && pwrite && !pslverr;

	// Cycles since a write that may move a pin; saturates so the hold check can start
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			en_ff  <= 8'h00;
			pol_ff <= 8'h00;
			om_ff  <= 8'h00;
			qt_ff  <= 2'h0;
		end else begin
			if (wr_ok && paddr == tpp_pkg::OFS_OUT_EN)
				en_ff <= pwdata[7:0];
			if (wr_ok && paddr == tpp_pkg::OFS_OUT_POL)
				pol_ff <= pwdata[7:0];
			if (wr_ok && paddr == tpp_pkg::OFS_OUT_MODE)
				om_ff <= pwdata[7:0];
			if (wr_ok && (paddr == tpp_pkg::OFS_OUT_EN || paddr == tpp_pkg::OFS_OUT_LVL))
				qt_ff <= 2'h0;
			else if (qt_ff != 2'h3)
				qt_ff <= qt_ff + 2'h1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	AST_PREADY_ONE: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	AST_PREADY_WAIT: assert property ($rose(psel && penable) |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	AST_PREADY_CAUSE: assert property (pready |-> psel && penable && $past(penable))
		else $error("pready outside an access");
	AST_ERR_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_SLV_HELD: assert property (
		qt_ff == 2'h3 && !en_ff[SLV_CH] |-> $stable(pwm_output_pin))
		else $error("pwm pin moved with output disabled");
	AST_LEAD_HELD: assert property (
		qt_ff == 2'h3 && !en_ff[MST_CH] |-> $stable(lead_output_pin))
		else $error("lead pin moved with output disabled");
	AST_SLV_LVL: assert property (
		wr_ok && paddr == tpp_pkg::OFS_OUT_LVL && !en_ff[SLV_CH]
		|-> ##2 pwm_output_pin == $past(pwdata[SLV_CH], 2))
		else $error("pwm pin does not follow level write");
	AST_LEAD_LVL: assert property (
		wr_ok && paddr == tpp_pkg::OFS_OUT_LVL && !en_ff[MST_CH]
		|-> ##2 lead_output_pin == $past(pwdata[MST_CH], 2))
		else $error("lead pin does not follow level write");
	AST_END_LEVEL: assert property (
		follower_count_done_irq && en_ff[SLV_CH] && om_ff[SLV_CH]
		|=> pwm_output_pin == pol_ff[SLV_CH])
		else $error("pwm pin not inactive after follower end");
endmodule : tpp_top_chk

bind tpp_top tpp_top_chk #(.MST_CH(MST_CH), .SLV_CH(SLV_CH)) u_chk (
	.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.pwm_output_pin, .lead_output_pin, .follower_count_done_irq);

/* bench/tb_tpp_top.sv */
// Self-checking bench for the paired-channel PWM block
`timescale 1ns/1ns
module tb_tpp_top;
	logic        core_clk, rst_b, psel, penable, pwrite, fip;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, pwm, lead, lirq, firq;
	logic [33:0] q[$];
	logic [33:0] e;
	int          bad_count, checks_done;
	// Fields: 15 clock one, 14 lead trigger, 13 enable, 12 polarity, 7:4 lead, 3:0 follower
	localparam logic [15:0] CFG [7] = '{16'h6032, 16'h7043, 16'h6025, 16'hF053,
		16'h2032, 16'h4032, 16'h6030};

	tpp_top uut (
		.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .follower_input_pin(fip), .pwm_output_pin(pwm), .lead_output_pin(lead),
		.lead_count_done_irq(lirq), .follower_count_done_irq(firq));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [33:0] x);
		int n;
		q.push_back(x);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			results();
		end
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 34'h0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, {2'b10, x});
	endtask : rd

	task automatic wait_lirq();
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (lirq !== 1'b1 && n < 200);
		if (lirq !== 1'b1) begin
			bad_count++;
			results();
		end
	endtask : wait_lirq

	always @(posedge core_clk) begin
		if (pready === 1'b1) begin
			e = q.pop_front();
			check(pslverr, e[32]);
			if (e[33])
				check(prdata, e[31:0]);
		end
	end

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	initial begin
		int i, p, act, w, l, f, xa, fc;
		logic [15:0] c;
		logic [31:0] d;
		{rst_b, psel, penable, pwrite, paddr, pwdata, fip} = '0;
		void'($urandom(32'h9EEC));
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (i = 0; i < 12; i++)
			rd(8'(i * 4), 32'h0);
		apb(1'b1, 8'h30, 32'hFFFF_FFFF, {2'b01, 32'h0});
		apb(1'b0, 8'h30, 32'h0, {2'b11, 32'h0});
		wr(tpp_pkg::OFS_SLV_MODE, 32'hFFFF_FFFF);
		rd(tpp_pkg::OFS_SLV_MODE, {16'h0, tpp_pkg::MODE_WMASK});
		wr(tpp_pkg::OFS_LEAD_MODE, 32'hFFFF_FFFF);
		rd(tpp_pkg::OFS_LEAD_MODE, {16'h0, tpp_pkg::MODE_WMASK & ~tpp_pkg::MODE_CHAIN_MASK});
		wr(tpp_pkg::OFS_OUT_POL, 32'hFF);
		rd(tpp_pkg::OFS_OUT_POL, {24'h0, tpp_pkg::OUT_FIX_WMASK});
		wr(tpp_pkg::OFS_OUT_MODE, 32'hFF);
		rd(tpp_pkg::OFS_OUT_MODE, {24'h0, tpp_pkg::OUT_FIX_WMASK});
		repeat (4) begin
			d = $urandom;
			wr(tpp_pkg::OFS_OUT_LVL, d);
			repeat (2) @(posedge core_clk);
			check(pwm, d[1]);
			check(lead, d[0]);
		end
		for (i = 0; i < 7; i++) begin
			c = CFG[i];
			wr(tpp_pkg::OFS_CTRL, 32'h0);
			wr(tpp_pkg::OFS_OUT_EN, 32'h0);
			wr(tpp_pkg::OFS_OUT_LVL, {30'h0, c[12], 1'b0});
			wr(tpp_pkg::OFS_OUT_POL, {30'h0, c[12], 1'b0});
			wr(tpp_pkg::OFS_PRESC, 32'h10);
			wr(tpp_pkg::OFS_SLV_MODE, {16'h0, c[15], 4'h0, c[14], 10'h009});
			wr(tpp_pkg::OFS_LEAD_MODE, {16'h0, c[15], 15'h0001});
			wr(tpp_pkg::OFS_LEAD_DATA, {28'h0, c[7:4]});
			wr(tpp_pkg::OFS_FOL_DATA, {28'h0, c[3:0]});
			wr(tpp_pkg::OFS_OUT_EN, {30'h0, c[13], 1'b0});
			wr(tpp_pkg::OFS_CTRL, 32'h1);
			wait_lirq();
			wait_lirq();
			// Any window of whole periods holds the same active count
			l = int'(c[7:4]) + 1;
			f = (int'(c[3:0]) < l) ? int'(c[3:0]) : l;
			w = (3 * l) << c[15];
			xa = (c[14] && c[13]) ? (3 * f) << c[15] : 0;
			p = 0;
			act = 0;
			fc = 0;
			repeat (w) begin
				@(posedge core_clk);
				fip <= 1'($urandom);
				p += int'(lirq === 1'b1);
				act += int'(pwm !== c[12]);
				fc += int'(firq === 1'b1);
			end
			check(p, 3);
			check(act, xa);
			// Follower end fires only when it counts out before the next reload
			check(fc, (c[14] && f > 0 && f < l) ? 3 : 0);
		end
		results();
	end
endmodule : tb_tpp_top
